/* verilog/gxl_phy_if.sv */
// phy-side gmii signalling: tx decode, rx framing and rx indications
// How it works
// - tx error in frame gives invalid group
// - data to extend sends delimiter first
// - tx codes: 0f extend, 1f err, 01 lpi
// - burst gaps filled with carrier extension
// - rx valid gapless, drops after last
// - rx valid starts by sfd, no eof
// - one octet per rx clock, bit0 lsb
// - false carrier: er high, code 0e
// - lpi receive: er high, code 01
// - loopback select only blocks medium events, no tx-to-rx path
// - rx decode table for host side
// - rx error while valid on errors
// - extension only after frame data or extension
// - full sfd passed for every frame
`timescale 1ns/1ps
`default_nettype none
module gxl_phy_if
	import gxl_pkg::*;
(
	input wire logic clk_sys_in, // system clock, medium side
	input wire logic rst_b_in, // sync reset, system domain
	input wire logic gtx_clk_in, // transmit clock from the host
	input wire logic rx_clk_in, // receive clock, phy owned
	input wire logic rx_rst_b_in, // sync reset, rx domain
	input wire logic tx_en_in,
	input wire logic tx_er_in,
	input wire logic [7:0] txd_in,
	output logic [2:0] tx_sym_out, // line symbol, gtx domain
	output logic [7:0] tx_sym_data_out,
	output logic tx_lpi_out,
	input wire logic loopback_in, // loopback select, only blocks medium events
	input wire logic med_valid_in, // medium octet strobe, sys domain
	input wire logic [7:0] med_data_in,
	input wire logic med_sfd_in, // octet is the sfd
	input wire logic med_last_in, // final octet of frame
	input wire logic med_err_in, // coding error in octet
	input wire logic med_ext_in, // extension symbol after frame
	input wire logic med_ext_err_in, // errored extension symbol
	input wire logic med_false_in, // false carrier seen
	input wire logic med_lpi_in, // link partner in lpi (level)
	output logic rx_dv_out,
	output logic rx_er_out,
	output logic [7:0] rxd_out
);
	// tx side on the host's clock; reset crossed over by two flops
	logic tx_rst_b;
	gxl_sync #(.WIDTH(1)) u_tx_rst (
		.clk_in(gtx_clk_in),
		.rst_b_in(1'b1),
		.async_in(rst_b_in),
		.sync_out(tx_rst_b)
	);
	gxl_tx_enc u_tx (
		.clk_in(gtx_clk_in),
		.rst_b_in(tx_rst_b),
		.tx_en_in(tx_en_in),
		.tx_er_in(tx_er_in),
		.txd_in(txd_in),
		.sym_out(tx_sym_out),
		.sym_data_out(tx_sym_data_out),
		.lpi_out(tx_lpi_out)
	);

	// medium events are captured in sys domain and handed over by toggle
	logic [7:0] hs_data; // held octet, stable while toggle crosses
	logic [5:0] hs_kind; // sfd,last,err,ext,exterr,false
	logic hs_tgl; // flips once per event
	wire [5:0] ev_kind = {med_sfd_in, med_last_in, med_err_in, med_ext_in,
		med_ext_err_in, med_false_in};
	wire ev_take = med_valid_in | med_ext_in | med_ext_err_in | med_false_in;
	wire ev_ok = ev_take & ~loopback_in;

	// capture one medium event; source paces below rx clock rate
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			hs_data <= GXL_CODE_IDLE;
			hs_kind <= '0;
			hs_tgl <= 1'b0;
		end else if (ev_ok) begin
			hs_data <= med_data_in;
			hs_kind <= ev_kind;
			hs_tgl <= ~hs_tgl;
		end
	end

	// cross toggle and lpi level into rx domain
	logic [1:0] rx_sync;
	gxl_sync #(.WIDTH(2)) u_rx_sync (
		.clk_in(rx_clk_in),
		.rst_b_in(rx_rst_b_in),
		.async_in({hs_tgl, med_lpi_in}),
		.sync_out(rx_sync)
	);
	logic tgl_seen; // last toggle value consumed
	wire ev_new = rx_sync[1] ^ tgl_seen;
	wire lpi_lvl = rx_sync[0];
	// fields are stable once the toggle has crossed
	wire k_sfd = hs_kind[5];
	wire k_last = hs_kind[4];
	wire k_err = hs_kind[3];
	wire k_ext = hs_kind[2];
	wire k_exterr = hs_kind[1];
	wire k_false = hs_kind[0];

	gxl_rx_state_t state, next_state;
	logic ext_ok; // last event shown was frame data or extension; lpi clears it
	logic next_dv, next_er;
	logic [7:0] next_rxd;
	// extension codes as the host decodes them
	wire next_is_ext = next_er & ~next_dv & ((next_rxd == GXL_CODE_EXTEND)
		| (next_rxd == GXL_CODE_EXTEND_ERR));
	// permission survives the idle wait between paced medium events;
	// only a new event or an lpi indication decides it again
	wire next_ext_ok = ev_new ? (next_dv | next_is_ext)
		: (ext_ok & (next_state != GXL_RX_LPI));

	// receive framing decisions
	always_comb begin
		next_state = state;
		next_dv = 1'b0;
		next_er = 1'b0;
		next_rxd = GXL_CODE_IDLE;
		case (state)
			GXL_RX_IDLE, GXL_RX_EXTEND, GXL_RX_FALSE: begin
				if (ev_new & k_sfd & ~k_false) begin
					next_dv = 1'b1;
					next_er = k_err;
					next_rxd = hs_data;
					next_state = k_last ? GXL_RX_IDLE : GXL_RX_FRAME;
				end else if (ev_new & (k_ext | k_exterr) & ext_ok) begin
					next_er = 1'b1;
					next_rxd = k_exterr ? GXL_CODE_EXTEND_ERR : GXL_CODE_EXTEND;
					next_state = GXL_RX_EXTEND;
				end else if (ev_new & k_false) begin
					next_er = 1'b1;
					next_rxd = GXL_CODE_FALSE_CARRIER;
					next_state = GXL_RX_FALSE;
				end else if (lpi_lvl) begin
					next_er = 1'b1;
					next_rxd = GXL_CODE_LPI;
					next_state = GXL_RX_LPI;
				end else begin
					next_state = GXL_RX_IDLE;
				end
			end
			GXL_RX_FRAME, GXL_RX_HOLD: begin
				next_dv = 1'b1;
				// repeat own octet: held word may be changing mid-crossing
				next_rxd = rxd_out;
				if (ev_new) begin
					next_rxd = hs_data;
					next_er = k_err;
					next_state = k_last ? GXL_RX_IDLE : GXL_RX_FRAME;
				end else begin
					// octet not yet arrived: repeat with error, no gap
					next_er = 1'b1;
					next_state = GXL_RX_HOLD;
				end
			end
			GXL_RX_LPI: begin
				if (lpi_lvl) begin
					next_er = 1'b1;
					next_rxd = GXL_CODE_LPI;
				end else begin
					next_state = GXL_RX_IDLE;
				end
			end
			default: begin
				next_state = GXL_RX_IDLE;
			end
		endcase
	end

	// rx registers, outputs from flops
	always_ff @(posedge rx_clk_in) begin
		if (!rx_rst_b_in) begin
			state <= GXL_RX_IDLE;
			tgl_seen <= 1'b0;
			ext_ok <= 1'b0;
			rx_dv_out <= 1'b0;
			rx_er_out <= 1'b0;
			rxd_out <= GXL_CODE_IDLE;
		end else begin
			state <= next_state;
			tgl_seen <= rx_sync[1];
			ext_ok <= next_ext_ok;
			rx_dv_out <= next_dv;
			rx_er_out <= next_er;
			rxd_out <= next_rxd;
		end
	end
endmodule : gxl_phy_if
`default_nettype wire

/* verilog/gxl_pkg.sv */
// shared constants for the gmii phy-side signalling block
package gxl_pkg;
	// tx request and rx indication codes, with enable or valid low and error high; 00 is idle
	localparam logic [7:0] GXL_CODE_IDLE = 8'h00;
	localparam logic [7:0] GXL_CODE_LPI = 8'h01;
	localparam logic [7:0] GXL_CODE_FALSE_CARRIER = 8'h0e;
	localparam logic [7:0] GXL_CODE_EXTEND = 8'h0f;
	localparam logic [7:0] GXL_CODE_EXTEND_ERR = 8'h1f;
	// line symbols toward the medium model (one per tx clock)
	localparam logic [2:0] GXL_SYM_IDLE = 3'h0;
	localparam logic [2:0] GXL_SYM_DATA = 3'h1;
	localparam logic [2:0] GXL_SYM_EOP = 3'h2;
	localparam logic [2:0] GXL_SYM_EXT = 3'h3;
	localparam logic [2:0] GXL_SYM_EXT_ERR = 3'h4;
	localparam logic [2:0] GXL_SYM_INVALID = 3'h5;
	localparam logic [2:0] GXL_SYM_LPI = 3'h6;
	// receive framing states, one-hot over six bits
	typedef enum logic [5:0] {
		GXL_RX_IDLE = 6'b000001,
		GXL_RX_FRAME = 6'b000010,
		GXL_RX_EXTEND = 6'b000100,
		GXL_RX_LPI = 6'b001000,
		GXL_RX_FALSE = 6'b010000,
		GXL_RX_HOLD = 6'b100000
	} gxl_rx_state_t;
endpackage : gxl_pkg

/* verilog/gxl_sync.sv */
// two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module gxl_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta; // first stage, read only by second stage

	// two flops, no logic between them
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			meta <= '0;
			sync_out <= '0;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule : gxl_sync
`default_nettype wire

/* verilog/gxl_tx_enc.sv */
// transmit-side decode of enable/error/data into line symbols
`timescale 1ns/1ps
`default_nettype none
module gxl_tx_enc
	import gxl_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic tx_en_in,
	input wire logic tx_er_in,
	input wire logic [7:0] txd_in,
	output logic [2:0] sym_out,
	output logic [7:0] sym_data_out,
	output logic lpi_out
);
	logic prev_data; // last cycle was clean data
	logic [2:0] next_sym;
	wire is_data = tx_en_in & ~tx_er_in;
	wire is_err = tx_en_in & tx_er_in;
	wire is_req = ~tx_en_in & tx_er_in;
	wire want_ext = is_req & (txd_in == GXL_CODE_EXTEND);
	wire want_exterr = is_req & (txd_in == GXL_CODE_EXTEND_ERR);
	wire want_lpi = is_req & (txd_in == GXL_CODE_LPI);

	// symbol selection
	always_comb begin
		next_sym = GXL_SYM_IDLE;
		if (is_err) begin
			next_sym = GXL_SYM_INVALID;
		end else if (is_data) begin
			next_sym = GXL_SYM_DATA;
		end else if ((want_ext | want_exterr) & prev_data) begin
			next_sym = GXL_SYM_EOP;
		end else if (want_ext) begin
			next_sym = GXL_SYM_EXT;
		end else if (want_exterr) begin
			next_sym = GXL_SYM_EXT_ERR;
		end else if (want_lpi) begin
			next_sym = GXL_SYM_LPI;
		end
	end

	// registered line outputs
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			sym_out <= GXL_SYM_IDLE;
			sym_data_out <= GXL_CODE_IDLE;
			lpi_out <= 1'b0;
			prev_data <= 1'b0;
		end else begin
			sym_out <= next_sym;
			sym_data_out <= txd_in;
			lpi_out <= want_lpi;
			// errored frame cycles go out as invalid symbols directly
			prev_data <= is_data;
		end
	end
endmodule : gxl_tx_enc
`default_nettype wire

/* tb/gxl_phy_if_assertions.sv */
// checker for the phy-side gmii signalling block
`timescale 1ns/1ps
`default_nettype none
module gxl_phy_if_assertions
	import gxl_pkg::*;
(
	input wire logic gtx_clk_in,
	input wire logic rx_clk_in,
	input wire logic rst_b_in,
	input wire logic rx_rst_b_in,
	input wire logic tx_en_in,
	input wire logic tx_er_in,
	input wire logic [7:0] txd_in,
	input wire logic [2:0] tx_sym_out,
	input wire logic tx_lpi_out,
	input wire logic rx_dv_out,
	input wire logic rx_er_out,
	input wire logic [7:0] rxd_out
);
	// request decode shared by the tx properties
	wire logic dat = tx_en_in && !tx_er_in;
	wire logic ext = !tx_en_in && tx_er_in && txd_in == GXL_CODE_EXTEND;
	wire logic exe = !tx_en_in && tx_er_in && txd_in == GXL_CODE_EXTEND_ERR;
	wire logic lpi = !tx_en_in && tx_er_in && txd_in == GXL_CODE_LPI;
	// extension shown on the rx side
	wire logic cx = rx_er_out && !rx_dv_out && (rxd_out == 8'h0f || rxd_out == 8'h1f);
	// frame data seen, with nothing but idle or extension since
	logic ext_hist;

	// history of what may precede an extension on the rx side
	always_ff @(posedge rx_clk_in) begin
		if (!rx_rst_b_in) begin
			ext_hist <= 1'b0;
		end else begin
			ext_hist <= rx_dv_out || cx || (ext_hist && !rx_er_out);
		end
	end

	tx_data_a: assert property (@(posedge gtx_clk_in) disable iff (!rst_b_in)
		dat |=> tx_sym_out == GXL_SYM_DATA) else $error("tx data symbol wrong");
	tx_err_a: assert property (@(posedge gtx_clk_in) disable iff (!rst_b_in)
		tx_en_in && tx_er_in |=> tx_sym_out == GXL_SYM_INVALID) else $error("no invalid group");
	ext_eop_a: assert property (@(posedge gtx_clk_in) disable iff (!rst_b_in)
		dat ##1 ext |=> tx_sym_out == GXL_SYM_EOP) else $error("no delimiter before extend");
	ext_fill_a: assert property (@(posedge gtx_clk_in) disable iff (!rst_b_in)
		dat ##1 ext ##1 ext |=> tx_sym_out == GXL_SYM_EXT) else $error("extend fill wrong");
	ext_err_a: assert property (@(posedge gtx_clk_in) disable iff (!rst_b_in)
		ext ##1 exe |=> tx_sym_out == GXL_SYM_EXT_ERR) else $error("extend error lost");
	lpi_req_a: assert property (@(posedge gtx_clk_in) disable iff (!rst_b_in)
		lpi |=> tx_lpi_out && tx_sym_out == GXL_SYM_LPI) else $error("lpi request lost");
	rx_code_a: assert property (@(posedge rx_clk_in) disable iff (!rx_rst_b_in)
		rx_er_out && !rx_dv_out |-> rxd_out inside {8'h01, 8'h0e, 8'h0f, 8'h1f})
		else $error("reserved rx code");
	rx_ext_a: assert property (@(posedge rx_clk_in) disable iff (!rx_rst_b_in)
		cx |-> ext_hist) else $error("lone rx extension");
endmodule : gxl_phy_if_assertions
`default_nettype wire

/* tb/gxl_host_model.sv */
// host-side transmit model: makes the tx clock and drives tx requests
`timescale 1ns/1ps
`default_nettype none
module gxl_host_model (
	output logic gtx_clk_out,
	output logic tx_en_out,
	output logic tx_er_out,
	output logic [7:0] txd_out
);
	// free-running tx clock, never halted in lpi
	initial gtx_clk_out = 1'b0;
	always #4 gtx_clk_out = ~gtx_clk_out;
	initial {tx_en_out, tx_er_out, txd_out} = 10'h000;
	// set at a falling edge, held one full cycle
	task automatic step(input logic en, input logic er, input logic [7:0] d);
		{tx_en_out, tx_er_out, txd_out} = {en, er, d};
		@(negedge gtx_clk_out);
	endtask : step
endmodule : gxl_host_model
`default_nettype wire

/* tb/gxl_phy_if_tb.sv */
// testbench for the phy-side gmii signalling block
`timescale 1ns/1ps
`default_nettype none
module gxl_phy_if_tb
	import gxl_pkg::*;
;
	logic clk_sys_in = 1'b0, rx_clk_in = 1'b0, rst_b_in = 1'b0, rx_rst_b_in = 1'b0;
	logic loopback_in = 1'b0, med_lpi_in = 1'b0;
	logic [6:0] ev = 7'h00; // packed medium event strobes
	logic [7:0] med_data_in = 8'h00;
	wire logic med_valid_in, med_sfd_in, med_last_in, med_err_in, med_ext_in;
	wire logic med_ext_err_in, med_false_in, gtx_clk_in, tx_en_in, tx_er_in;
	wire logic tx_lpi_out, rx_dv_out, rx_er_out;
	wire logic [7:0] txd_in, tx_sym_data_out, rxd_out;
	wire logic [2:0] tx_sym_out;
	int n_mismatch = 0, n_tests = 0;
	logic [7:0] q_dat[$], q_cod[$];
	logic [9:0] prev = 10'h000;
	assign {med_valid_in, med_sfd_in, med_last_in, med_err_in, med_ext_in, med_ext_err_in,
		med_false_in} = ev;
	// clocks; the link clock is offset so edges never line up
	always #20 clk_sys_in = ~clk_sys_in;
	initial #7 forever #40 rx_clk_in = ~rx_clk_in;
	gxl_host_model HOST (.gtx_clk_out(gtx_clk_in), .tx_en_out(tx_en_in), .tx_er_out(tx_er_in),
		.txd_out(txd_in));
	gxl_phy_if DUT (.clk_sys_in, .rst_b_in, .gtx_clk_in, .rx_clk_in, .rx_rst_b_in, .tx_en_in,
		.tx_er_in, .txd_in, .tx_sym_out, .tx_sym_data_out, .tx_lpi_out, .loopback_in,
		.med_valid_in, .med_data_in, .med_sfd_in, .med_last_in, .med_err_in, .med_ext_in,
		.med_ext_err_in, .med_false_in, .med_lpi_in, .rx_dv_out, .rx_er_out, .rxd_out);
	// host view: clean octets and each new out-of-frame code
	// sampled mid-cycle, away from the edge that launches the outputs
	always @(negedge rx_clk_in) begin
		if (rx_dv_out === 1'b1 && rx_er_out === 1'b0)
			q_dat.push_back(rxd_out);
		if (rx_dv_out === 1'b0 && rx_er_out === 1'b1 && prev !== {rx_dv_out, rx_er_out, rxd_out})
			q_cod.push_back(rxd_out);
		prev <= {rx_dv_out, rx_er_out, rxd_out};
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	// one event strobe for a sys cycle, then the spacing the rx side needs
	task automatic med(input logic [6:0] f, input logic [7:0] d);
		@(negedge clk_sys_in);
		ev = f;
		med_data_in = d;
		@(negedge clk_sys_in);
		ev = 7'h00;
		repeat (6) @(negedge clk_sys_in);
	endtask : med
	// tx walk: frame, errored octet, extension, extend error, lpi in and out
	task automatic t_tx();
		logic [12:0] s [10] = '{{2'b10, 8'h55, GXL_SYM_DATA}, {2'b11, 8'h00, GXL_SYM_INVALID},
			{2'b10, 8'haa, GXL_SYM_DATA}, {2'b01, 8'h0f, GXL_SYM_EOP},
			{2'b01, 8'h0f, GXL_SYM_EXT}, {2'b01, 8'h1f, GXL_SYM_EXT_ERR},
			{2'b00, 8'h00, GXL_SYM_IDLE}, {2'b01, 8'h01, GXL_SYM_LPI},
			{2'b01, 8'h01, GXL_SYM_LPI}, {2'b00, 8'h00, GXL_SYM_IDLE}};
		// no frame data is offered right after lpi exit
		HOST.step(1'b0, 1'b0, 8'h00);
		for (int i = 0; i < 10; i++) begin
			HOST.step(s[i][12], s[i][11], s[i][10:3]);
			chk({5'h00, tx_sym_out}, {5'h00, s[i][2:0]});
			chk({7'h00, tx_lpi_out}, {7'h00, s[i][2:0] == GXL_SYM_LPI});
			chk(tx_sym_data_out, s[i][10:3]);
		end
		$display("tx test done");
	endtask : t_tx
	// frame with an errored octet, then extension and extend error
	task automatic t_frame();
		q_dat = {};
		q_cod = {};
		med(7'h60, 8'hd5);
		med(7'h40, 8'h3c);
		med(7'h48, 8'h11);
		med(7'h50, 8'ha7);
		med(7'h04, 8'h00);
		med(7'h02, 8'h00);
		repeat (6) @(negedge rx_clk_in);
		chk(8'(q_dat.size()), 8'h03);
		chk(q_dat[0], 8'hd5);
		chk(q_dat[2], 8'ha7);
		chk(q_cod[0], 8'h0f);
		chk(q_cod[1], 8'h1f);
		chk({7'h00, rx_dv_out}, 8'h00);
		$display("frame test done");
	endtask : t_frame
	// false carrier, lone extension, lpi, and a frame while in loopback
	task automatic t_side();
		q_dat = {};
		q_cod = {};
		med(7'h01, 8'h00);
		med(7'h04, 8'h00);
		med_lpi_in = 1'b1;
		repeat (8) @(negedge clk_sys_in);
		med_lpi_in = 1'b0;
		loopback_in = 1'b1;
		med(7'h60, 8'hd5);
		med(7'h50, 8'h77);
		loopback_in = 1'b0;
		repeat (6) @(negedge rx_clk_in);
		chk(8'(q_cod.size()), 8'h02);
		chk(q_cod[0], 8'h0e);
		chk(q_cod[1], 8'h01);
		chk(8'(q_dat.size()), 8'h00);
		$display("side test done");
	endtask : t_side
	initial begin
		repeat (16) @(negedge clk_sys_in);
		rst_b_in = 1'b1;
		rx_rst_b_in = 1'b1;
		repeat (8) @(negedge clk_sys_in);
		t_tx();
		t_frame();
		t_side();
		summarize();
	end
	// watchdog: a hang counts as a mismatch
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		n_mismatch++;
		summarize();
	end
endmodule : gxl_phy_if_tb
bind gxl_phy_if gxl_phy_if_assertions CHK (.gtx_clk_in, .rx_clk_in, .rst_b_in, .rx_rst_b_in,
	.tx_en_in, .tx_er_in, .txd_in, .tx_sym_out, .tx_lpi_out, .rx_dv_out, .rx_er_out, .rxd_out);
`default_nettype wire
